// File: dtc_consts.svh
// offsets, field positions, reset values and counts of the debug trace compare unit
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

`define DTC_ADDR_W 4
`define DTC_OFF_CMPA_HI 4'h0
`define DTC_OFF_CMPA_LO 4'h1
`define DTC_OFF_CMPB_HI 4'h2
`define DTC_OFF_CMPB_LO 4'h3
`define DTC_OFF_TRACE_HI 4'h4
`define DTC_OFF_TRACE_LO 4'h5
`define DTC_OFF_CTL 4'h6
`define DTC_OFF_TRG 4'h7
`define DTC_OFF_STAT 4'h8
`define DTC_OFF_FRST 4'h9

`define DTC_CTL_EN 7
`define DTC_CTL_ARM 6
`define DTC_CTL_TAG 5
`define DTC_CTL_BREAK_REQUEST_ENABLE 4
`define DTC_CTL_RWA 3
`define DTC_CTL_CMP_A_DIRECTION_QUALIFY 2
`define DTC_CTL_RWB 1
`define DTC_CTL_CMP_B_DIRECTION_QUALIFY 0
`define DTC_FRST_BIT 0
`define DTC_TRG_BEGIN 6
`define DTC_TRG_MASK 8'hCF
`define DTC_STAT_AF 7
`define DTC_STAT_BF 6
`define DTC_STAT_CAPTURE_ACTIVE_FLAG 5

`define DTC_TRG_A_ONLY 4'h0
`define DTC_TRG_A_OR_B 4'h1
`define DTC_TRG_EVENT_B 4'h3

`define DTC_RST_BYTE 8'h00
`define DTC_RST_WORD 16'h0000
`define DTC_FIFO_DEPTH 8
`define DTC_CNT_FULL 4'h8
`define DTC_CNT_LAST 4'h7

`define DTC_HOFF_TGT_ADDR 3'h0
`define DTC_HOFF_TGT_DATA 3'h1
`define DTC_HOFF_CMD 3'h2
`define DTC_HOFF_RES_LO 3'h3
`define DTC_HOFF_RES_HI 3'h4
`define DTC_HOFF_STATUS 3'h5
`define DTC_CMD_WRITE 0
`define DTC_CMD_READ 1
`define DTC_CMD_BKGD 2
`define DTC_CMD_WORD 3
`define DTC_CMD_PRIME 4
`define DTC_PRIME_READS 4'h8

`endif

// File: dtc_pkg.sv
// types of the debug host end of the debug trace compare link
package dtc_pkg;
    typedef enum logic [1:0] {HOST_IDLE, HOST_ISSUE, HOST_CAPTURE} dtc_host_state_t;
    typedef enum logic [1:0] {STEP_SINGLE, STEP_STATUS, STEP_HIGH, STEP_LOW} dtc_step_t;
endpackage

// File: dtc_if.sv
// register link between the debug host and the trace compare unit
`timescale 1ns/1ps
`include "dtc_consts.svh"
interface dtc_if;
    logic [`DTC_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic bkgd;
    logic [7:0] rdata;
    modport dev (input addr, input wdata, input wr, input rd, input bkgd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, output bkgd, input rdata);
endinterface

// File: dtc_device.sv
// debug trace compare unit: comparators, trace fifo, control and forced reset
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_device (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    dtc_if.dev link,
    input wire logic [15:0] cpuAddr,
    input wire logic [7:0] cpuData,
    input wire logic cpuValid,
    input wire logic cpuRead,
    input wire logic cpuFetch,
    input wire logic secure,
    output logic breakReq,
    output logic breakTag,
    output logic mcuReset
);
    logic [15:0] cmpA_q, cmpA_d, cmpB_q, cmpB_d;
    logic [7:0] ctl_q, ctl_d, trg_q, trg_d, rdata_q, rdata_d;
    logic armed_q, armed_d, started_q, started_d;
    logic flagA_q, flagA_d, flagB_q, flagB_d;
    logic [3:0] cnt_q, cnt_d;
    logic [15:0] fifo_q [0:`DTC_FIFO_DEPTH-1];
    logic [15:0] fifo_d [0:`DTC_FIFO_DEPTH-1];
    logic [15:0] lastFetch_q, lastFetch_d;
    logic brk_q, brk_d, tag_q, tag_d, frst_q, frst_d;
    logic matchA, matchB, enable, eventOnly, beginTrace, trigger;
    logic store, runEnd, shiftEn;
    logic [15:0] shiftVal;

    always_comb begin
        cmpA_d = cmpA_q;
        cmpB_d = cmpB_q;
        ctl_d = ctl_q;
        trg_d = trg_q;
        armed_d = armed_q;
        started_d = started_q;
        flagA_d = flagA_q;
        flagB_d = flagB_q;
        cnt_d = cnt_q;
        fifo_d = fifo_q;
        lastFetch_d = lastFetch_q;
        rdata_d = `DTC_RST_BYTE;
        brk_d = 1'b0;
        frst_d = 1'b0;
        tag_d = ctl_q[`DTC_CTL_TAG];
        store = 1'b0;
        runEnd = 1'b0;
        shiftEn = 1'b0;
        shiftVal = cpuAddr;

        matchA = cpuValid && (cpuAddr == cmpA_q) &&
                 (!ctl_q[`DTC_CTL_CMP_A_DIRECTION_QUALIFY] || (cpuRead == ctl_q[`DTC_CTL_RWA]));
        matchB = cpuValid && (cpuAddr == cmpB_q) &&
                 (!ctl_q[`DTC_CTL_CMP_B_DIRECTION_QUALIFY] || (cpuRead == ctl_q[`DTC_CTL_RWB]));
        enable = ctl_q[`DTC_CTL_EN];
        eventOnly = (trg_q[3:0] == `DTC_TRG_EVENT_B);
        // event-only runs are always begin traces
        beginTrace = trg_q[`DTC_TRG_BEGIN] || eventOnly;
        trigger = 1'b0;
        if (trg_q[3:0] == `DTC_TRG_A_ONLY) begin
            trigger = matchA;
        end else if (trg_q[3:0] == `DTC_TRG_A_OR_B) begin
            trigger = matchA || matchB;
        end else if (eventOnly) begin
            trigger = matchB;
        end

        if (cpuValid && cpuFetch) begin
            lastFetch_d = cpuAddr;
        end

        if (armed_q && enable) begin
            if (matchA) begin
                flagA_d = 1'b1;
            end
            if (matchB) begin
                flagB_d = 1'b1;
            end
            if (eventOnly) begin
                store = matchB;
                shiftVal = {8'h00, cpuData};
            end else if (beginTrace) begin
                store = cpuValid && cpuFetch && (started_q || trigger);
            end else begin
                store = cpuValid && cpuFetch;
            end
            if (trigger) begin
                started_d = 1'b1;
            end
            // end trace stops at the trigger, begin trace when the eighth word lands
            if (!beginTrace && trigger) begin
                runEnd = 1'b1;
            end
            if (beginTrace && store && (cnt_q == `DTC_CNT_LAST)) begin
                runEnd = 1'b1;
            end
        end
        if (store) begin
            shiftEn = 1'b1;
            if (cnt_q != `DTC_CNT_FULL) begin
                cnt_d = cnt_q + 4'h1;
            end
        end
        if (runEnd) begin
            armed_d = 1'b0;
            brk_d = ctl_q[`DTC_CTL_BREAK_REQUEST_ENABLE];
        end

        if (link.rd) begin
            if (link.addr == `DTC_OFF_CMPA_HI) begin
                rdata_d = cmpA_q[15:8];
            end else if (link.addr == `DTC_OFF_CMPA_LO) begin
                rdata_d = cmpA_q[7:0];
            end else if (link.addr == `DTC_OFF_CMPB_HI) begin
                rdata_d = cmpB_q[15:8];
            end else if (link.addr == `DTC_OFF_CMPB_LO) begin
                rdata_d = cmpB_q[7:0];
            end else if (link.addr == `DTC_OFF_TRACE_HI) begin
                rdata_d = eventOnly ? `DTC_RST_BYTE : fifo_q[0][15:8];
            end else if (link.addr == `DTC_OFF_TRACE_LO) begin
                rdata_d = fifo_q[0][7:0];
                // armed: data stays put so a run in progress is not disturbed
                if (!armed_q) begin
                    shiftEn = 1'b1;
                    shiftVal = lastFetch_q;
                end
            end else if (link.addr == `DTC_OFF_CTL) begin
                rdata_d = {ctl_q[7], armed_q, ctl_q[5:0]};
            end else if (link.addr == `DTC_OFF_TRG) begin
                rdata_d = trg_q;
            end else if (link.addr == `DTC_OFF_STAT) begin
                rdata_d = {flagA_q, flagB_q, armed_q, 1'b0, cnt_q};
            end else begin
                rdata_d = `DTC_RST_BYTE;
            end
        end

        if (shiftEn) begin
            for (int i = 0; i < `DTC_FIFO_DEPTH - 1; i++) begin
                fifo_d[i] = fifo_q[i + 1];
            end
            fifo_d[`DTC_FIFO_DEPTH - 1] = shiftVal;
        end

        // writes come last so a new arm wins over a run ending in the same cycle
        if (link.wr) begin
            if (link.addr == `DTC_OFF_FRST) begin
                if (link.bkgd && link.wdata[`DTC_FRST_BIT]) begin
                    frst_d = 1'b1;
                end
            end else if (link.addr == `DTC_OFF_CMPA_HI) begin
                if (!armed_q) begin
                    cmpA_d[15:8] = link.wdata;
                end
            end else if (link.addr == `DTC_OFF_CMPA_LO) begin
                if (!armed_q) begin
                    cmpA_d[7:0] = link.wdata;
                end
            end else if (link.addr == `DTC_OFF_CMPB_HI) begin
                if (!armed_q) begin
                    cmpB_d[15:8] = link.wdata;
                end
            end else if (link.addr == `DTC_OFF_CMPB_LO) begin
                if (!armed_q) begin
                    cmpB_d[7:0] = link.wdata;
                end
            end else if (link.addr == `DTC_OFF_CTL) begin
                ctl_d = link.wdata;
                ctl_d[`DTC_CTL_EN] = link.wdata[`DTC_CTL_EN] && !secure;
                ctl_d[`DTC_CTL_ARM] = 1'b0;
                armed_d = link.wdata[`DTC_CTL_ARM] && ctl_d[`DTC_CTL_EN];
                if (armed_d && !armed_q) begin
                    cnt_d = 4'h0;
                    started_d = 1'b0;
                    flagA_d = 1'b0;
                    flagB_d = 1'b0;
                end
            end else if (link.addr == `DTC_OFF_TRG) begin
                if (!armed_q) begin
                    trg_d = link.wdata & `DTC_TRG_MASK;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmpA_q <= `DTC_RST_WORD;
            cmpB_q <= `DTC_RST_WORD;
            ctl_q <= `DTC_RST_BYTE;
            trg_q <= `DTC_RST_BYTE;
            rdata_q <= `DTC_RST_BYTE;
            armed_q <= 1'b0;
            started_q <= 1'b0;
            flagA_q <= 1'b0;
            flagB_q <= 1'b0;
            cnt_q <= 4'h0;
            for (int i = 0; i < `DTC_FIFO_DEPTH; i++) begin
                fifo_q[i] <= `DTC_RST_WORD;
            end
            lastFetch_q <= `DTC_RST_WORD;
            brk_q <= 1'b0;
            tag_q <= 1'b0;
            frst_q <= 1'b0;
        end else if (ce) begin
            cmpA_q <= cmpA_d;
            cmpB_q <= cmpB_d;
            ctl_q <= ctl_d;
            trg_q <= trg_d;
            rdata_q <= rdata_d;
            armed_q <= armed_d;
            started_q <= started_d;
            flagA_q <= flagA_d;
            flagB_q <= flagB_d;
            cnt_q <= cnt_d;
            fifo_q <= fifo_d;
            lastFetch_q <= lastFetch_d;
            brk_q <= brk_d;
            tag_q <= tag_d;
            frst_q <= frst_d;
        end
    end

    assign link.rdata = rdata_q;
    assign breakReq = brk_q;
    assign breakTag = tag_q;
    assign mcuReset = frst_q;
endmodule

// File: dtc_host.sv
// debug host end: runs single, word and priming accesses over the register link
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_host (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    dtc_if.host link,
    input wire logic [2:0] swAddr,
    input wire logic [7:0] swWdata,
    input wire logic swWr,
    input wire logic swRd,
    output logic [7:0] swRdata
);
    dtc_pkg::dtc_host_state_t state_q, state_d;
    dtc_pkg::dtc_step_t step_q, step_d;
    logic [3:0] tgtAddr_q, tgtAddr_d, addr_q, addr_d, reps_q, reps_d;
    logic [7:0] tgtData_q, tgtData_d, resLo_q, resLo_d, resHi_q, resHi_d;
    logic [7:0] swRdata_q, swRdata_d;
    logic bkgd_q, bkgd_d, isWrite_q, isWrite_d, done_q, done_d, err_q, err_d;

    always_comb begin
        state_d = state_q;
        step_d = step_q;
        tgtAddr_d = tgtAddr_q;
        tgtData_d = tgtData_q;
        addr_d = addr_q;
        reps_d = reps_q;
        resLo_d = resLo_q;
        resHi_d = resHi_q;
        bkgd_d = bkgd_q;
        isWrite_d = isWrite_q;
        done_d = done_q;
        err_d = err_q;
        swRdata_d = 8'h00;

        if (swWr) begin
            if (swAddr == `DTC_HOFF_TGT_ADDR) begin
                tgtAddr_d = swWdata[3:0];
            end else if (swAddr == `DTC_HOFF_TGT_DATA) begin
                tgtData_d = swWdata;
            end
        end
        if (swRd) begin
            if (swAddr == `DTC_HOFF_TGT_ADDR) begin
                swRdata_d = {4'h0, tgtAddr_q};
            end else if (swAddr == `DTC_HOFF_TGT_DATA) begin
                swRdata_d = tgtData_q;
            end else if (swAddr == `DTC_HOFF_RES_LO) begin
                swRdata_d = resLo_q;
            end else if (swAddr == `DTC_HOFF_RES_HI) begin
                swRdata_d = resHi_q;
            end else if (swAddr == `DTC_HOFF_STATUS) begin
                swRdata_d = {5'h00, err_q, done_q, state_q != dtc_pkg::HOST_IDLE};
            end
        end

        case (state_q)
            dtc_pkg::HOST_IDLE: begin
                if (swWr && (swAddr == `DTC_HOFF_CMD)) begin
                    done_d = 1'b0;
                    err_d = 1'b0;
                    bkgd_d = swWdata[`DTC_CMD_BKGD];
                    isWrite_d = 1'b0;
                    reps_d = 4'h0;
                    // trace reads first check that no run is armed
                    if (swWdata[`DTC_CMD_WORD] || swWdata[`DTC_CMD_PRIME]) begin
                        step_d = dtc_pkg::STEP_STATUS;
                        addr_d = `DTC_OFF_STAT;
                        state_d = dtc_pkg::HOST_ISSUE;
                        if (!swWdata[`DTC_CMD_WORD]) begin
                            reps_d = `DTC_PRIME_READS;
                        end
                    end else if (swWdata[`DTC_CMD_WRITE] || swWdata[`DTC_CMD_READ]) begin
                        step_d = dtc_pkg::STEP_SINGLE;
                        addr_d = tgtAddr_q;
                        isWrite_d = swWdata[`DTC_CMD_WRITE];
                        state_d = dtc_pkg::HOST_ISSUE;
                    end
                end
            end
            dtc_pkg::HOST_ISSUE: begin
                if (isWrite_q) begin
                    done_d = 1'b1;
                    state_d = dtc_pkg::HOST_IDLE;
                end else begin
                    state_d = dtc_pkg::HOST_CAPTURE;
                end
            end
            default: begin
                state_d = dtc_pkg::HOST_ISSUE;
                case (step_q)
                    dtc_pkg::STEP_SINGLE: begin
                        resLo_d = link.rdata;
                        done_d = 1'b1;
                        state_d = dtc_pkg::HOST_IDLE;
                    end
                    dtc_pkg::STEP_STATUS: begin
                        if (link.rdata[`DTC_STAT_CAPTURE_ACTIVE_FLAG]) begin
                            err_d = 1'b1;
                            done_d = 1'b1;
                            state_d = dtc_pkg::HOST_IDLE;
                        end else if (reps_q != 4'h0) begin
                            step_d = dtc_pkg::STEP_LOW;
                            addr_d = `DTC_OFF_TRACE_LO;
                        end else begin
                            step_d = dtc_pkg::STEP_HIGH;
                            addr_d = `DTC_OFF_TRACE_HI;
                        end
                    end
                    dtc_pkg::STEP_HIGH: begin
                        resHi_d = link.rdata;
                        step_d = dtc_pkg::STEP_LOW;
                        addr_d = `DTC_OFF_TRACE_LO;
                    end
                    default: begin
                        if (reps_q > 4'h1) begin
                            reps_d = reps_q - 4'h1;
                        end else begin
                            if (reps_q == 4'h0) begin
                                resLo_d = link.rdata;
                            end
                            reps_d = 4'h0;
                            done_d = 1'b1;
                            state_d = dtc_pkg::HOST_IDLE;
                        end
                    end
                endcase
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= dtc_pkg::HOST_IDLE;
            step_q <= dtc_pkg::STEP_SINGLE;
            tgtAddr_q <= 4'h0;
            tgtData_q <= 8'h00;
            addr_q <= 4'h0;
            reps_q <= 4'h0;
            resLo_q <= 8'h00;
            resHi_q <= 8'h00;
            swRdata_q <= 8'h00;
            bkgd_q <= 1'b0;
            isWrite_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            step_q <= step_d;
            tgtAddr_q <= tgtAddr_d;
            tgtData_q <= tgtData_d;
            addr_q <= addr_d;
            reps_q <= reps_d;
            resLo_q <= resLo_d;
            resHi_q <= resHi_d;
            swRdata_q <= swRdata_d;
            bkgd_q <= bkgd_d;
            isWrite_q <= isWrite_d;
            done_q <= done_d;
            err_q <= err_d;
        end
    end

    assign link.addr = addr_q;
    assign link.wdata = tgtData_q;
    assign link.bkgd = bkgd_q;
    assign link.wr = (state_q == dtc_pkg::HOST_ISSUE) && isWrite_q;
    assign link.rd = (state_q == dtc_pkg::HOST_ISSUE) && !isWrite_q;
    assign swRdata = swRdata_q;
endmodule

// File: dtc_link_chk.sv
// concurrent checks on the register link between debug host and trace compare unit
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_link_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`DTC_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic bkgd,
    input wire logic [7:0] rdata,
    input wire logic breakReq,
    input wire logic mcuReset
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    // only a background write with bit zero set may start the system reset
    wire logic frstHitNow = wr && bkgd && addr == `DTC_OFF_FRST && wdata[`DTC_FRST_BIT];
    wire logic frstUserWr = wr && !bkgd && addr == `DTC_OFF_FRST;

    sequence frstHit;
        frstHitNow;
    endsequence
    sequence resetQuiet;
        !mcuReset [*2];
    endsequence

    strobe_excl_a: assert property (!(wr && rd)) else $error("write and read strobes together");
    wr_pulse_a: assert property (wr |=> !wr) else $error("write strobe longer than one cycle");
    rd_pulse_a: assert property (rd |=> !rd) else $error("read strobe longer than one cycle");
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00) else $error("read data outside slot");
    frst_read_a: assert property (rd && addr == `DTC_OFF_FRST |=> rdata == 8'h00)
        else $error("forced reset register read not zero");
    unmapped_read_a: assert property (rd && addr > `DTC_OFF_FRST |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    reset_issue_a: assert property (frstHit |-> ##[1:2] mcuReset)
        else $error("background reset write gave no system reset");
    reset_cause_a: assert property (mcuReset |-> $past(frstHitNow) || $past(frstHitNow, 2))
        else $error("system reset without background write");
    user_frst_a: assert property (frstUserWr |=> resetQuiet)
        else $error("user write to forced reset acted");
    reset_pulse_a: assert property (mcuReset |=> !mcuReset) else $error("system reset too long");
    break_pulse_a: assert property (breakReq |=> !breakReq) else $error("break request too long");
endmodule

// File: dtc_tb.sv
// self-checking bench: debug host and trace compare unit joined over their link
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_tb;
    logic clk;
    logic rst;
    logic [15:0] cpuAddr;
    logic [7:0] cpuData;
    logic cpuValid;
    logic cpuRead;
    logic cpuFetch;
    logic secure;
    logic breakReq;
    logic breakTag;
    logic mcuReset;
    logic [2:0] swAddr;
    logic [7:0] swWdata;
    logic swWr;
    logic swRd;
    logic [7:0] swRdata;
    logic [15:0] rstSeen = 16'h0000;
    logic [15:0] brkSeen = 16'h0000;
    int fails;
    int comparisons;

    dtc_if link();
    dtc_device u_dtc_device (.clk(clk), .rst(rst), .ce(1'b1), .link(link), .cpuAddr(cpuAddr),
        .cpuData(cpuData), .cpuValid(cpuValid), .cpuRead(cpuRead), .cpuFetch(cpuFetch),
        .secure(secure), .breakReq(breakReq), .breakTag(breakTag), .mcuReset(mcuReset));
    dtc_host u_dtc_host (.clk(clk), .rst(rst), .ce(1'b1), .link(link), .swAddr(swAddr),
        .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata));
    dtc_link_chk u_dtc_link_chk (.clk(clk), .rst(rst), .addr(link.addr), .wdata(link.wdata),
        .wr(link.wr), .rd(link.rd), .bkgd(link.bkgd), .rdata(link.rdata),
        .breakReq(breakReq), .mcuReset(mcuReset));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // pulses are counted rather than caught, so a late pulse still shows up
    always @(posedge clk) begin
        if (mcuReset === 1'b1) rstSeen <= rstSeen + 16'h0001;
        if (breakReq === 1'b1) brkSeen <= brkSeen + 16'h0001;
    end

    task automatic conclude;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic swWrite(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        swAddr <= a;
        swWdata <= d;
        swWr <= 1'b1;
        @(posedge clk);
        swWr <= 1'b0;
    endtask

    task automatic swRead(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        swAddr <= a;
        swRd <= 1'b1;
        @(posedge clk);
        swRd <= 1'b0;
        #1 v = swRdata;
    endtask

    // one host command to the unit; polls done with a bound, returns result hi and lo
    task automatic acc(input logic [7:0] idx, input logic [7:0] d, input logic [7:0] cmd,
            output logic [15:0] res);
        logic [7:0] s;
        logic [7:0] lo;
        int n;
        swWrite(3'h0, idx);
        swWrite(3'h1, d);
        swWrite(3'h2, cmd);
        s = 8'h00;
        n = 0;
        while (s[1] !== 1'b1 && n < 40) begin
            swRead(3'h5, s);
            n++;
        end
        if (s[1] !== 1'b1) fails++;
        swRead(3'h3, lo);
        swRead(3'h4, s);
        res = {s, lo};
    endtask

    task automatic wrReg(input logic [7:0] idx, input logic [7:0] d);
        logic [15:0] r;
        acc(idx, d, 8'h01, r);
    endtask

    task automatic rdChk(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp);
        logic [15:0] r;
        acc(idx, 8'h00, 8'h02, r);
        check({8'h00, r[7:0] & mask}, {8'h00, exp});
    endtask

    task automatic cpu(input logic [15:0] a, input logic [7:0] d, input logic rdn,
            input logic fetch);
        @(posedge clk);
        cpuAddr <= a;
        cpuData <= d;
        cpuRead <= rdn;
        cpuFetch <= fetch;
        cpuValid <= 1'b1;
        @(posedge clk);
        cpuValid <= 1'b0;
        cpuFetch <= 1'b0;
    endtask

    task automatic t_resetVals;
        for (int i = 0; i < 4; i++) rdChk(8'(i), 8'hFF, 8'h00);
        rdChk(8'h0A, 8'hFF, 8'h00);
    endtask

    task automatic t_forceReset;
        logic [15:0] r;
        wrReg(8'h09, 8'h01);
        check(rstSeen, 16'h0000);
        rdChk(8'h09, 8'hFF, 8'h00);
        acc(8'h09, 8'h01, 8'h05, r);
        check(rstSeen, 16'h0001);
    endtask

    task automatic t_endTrace;
        logic [15:0] r;
        logic [15:0] r2;
        logic [15:0] e;
        wrReg(8'h07, 8'h00);
        wrReg(8'h00, 8'h12);
        wrReg(8'h01, 8'h34);
        // a known last fetch makes a wrongly advancing armed read visible later
        cpu(16'h0ABC, 8'h00, 1'b1, 1'b1);
        wrReg(8'h06, 8'hF0);
        rdChk(8'h08, 8'h20, 8'h20);
        wrReg(8'h00, 8'h55);
        rdChk(8'h00, 8'hFF, 8'h12);
        acc(8'h05, 8'h00, 8'h02, r);
        acc(8'h05, 8'h00, 8'h02, r2);
        check({8'h00, r2[7:0]}, {8'h00, r[7:0]});
        cpu(16'h1000, 8'h00, 1'b1, 1'b1);
        cpu(16'h1001, 8'h00, 1'b1, 1'b1);
        cpu(16'h1234, 8'h00, 1'b1, 1'b1);
        rdChk(8'h08, 8'hAF, 8'h83);
        check(brkSeen, 16'h0001);
        check({15'h0000, breakTag}, 16'h0001);
        // five stale words precede the three captured ones, oldest first
        for (int i = 0; i < 8; i++) begin
            e = (i < 5) ? 16'h0000 : (i == 5) ? 16'h1000 : (i == 6) ? 16'h1001 : 16'h1234;
            acc(8'h00, 8'h00, 8'h08, r);
            check(r, e);
        end
        rdChk(8'h08, 8'h0F, 8'h03);
    endtask

    task automatic t_eventOnly;
        wrReg(8'h07, 8'h03);
        rdChk(8'h04, 8'hFF, 8'h00);
        wrReg(8'h02, 8'h20);
        wrReg(8'h03, 8'h00);
        wrReg(8'h06, 8'hD0);
        for (int i = 0; i < 8; i++) cpu(16'h2000, 8'(8'hA0 + i), 1'b0, 1'b0);
        rdChk(8'h08, 8'h2F, 8'h08);
        check(brkSeen, 16'h0002);
        check({15'h0000, breakTag}, 16'h0000);
        wrReg(8'h04, 8'hFF);
        rdChk(8'h04, 8'hFF, 8'h00);
        for (int i = 0; i < 8; i++) rdChk(8'h05, 8'hFF, 8'(8'hA0 + i));
    endtask

    task automatic t_direction;
        wrReg(8'h07, 8'h00);
        wrReg(8'h00, 8'h40);
        wrReg(8'h01, 8'h00);
        wrReg(8'h06, 8'hCC);
        cpu(16'h4000, 8'h00, 1'b0, 1'b0);
        cpu(16'h4001, 8'h00, 1'b1, 1'b0);
        rdChk(8'h08, 8'h20, 8'h20);
        cpu(16'h4000, 8'h00, 1'b1, 1'b0);
        rdChk(8'h08, 8'h20, 8'h00);
        check(brkSeen, 16'h0002);
        wrReg(8'h07, 8'h01);
        wrReg(8'h06, 8'hC1);
        cpu(16'h2000, 8'h00, 1'b1, 1'b0);
        rdChk(8'h08, 8'h60, 8'h20);
        cpu(16'h2000, 8'h00, 1'b0, 1'b0);
        rdChk(8'h08, 8'h60, 8'h40);
    endtask

    task automatic t_secure;
        @(posedge clk);
        secure <= 1'b1;
        wrReg(8'h06, 8'hC0);
        rdChk(8'h06, 8'hFF, 8'h00);
        @(posedge clk);
        secure <= 1'b0;
        wrReg(8'h06, 8'hC0);
        rdChk(8'h08, 8'h20, 8'h20);
        wrReg(8'h06, 8'h80);
        rdChk(8'h08, 8'h20, 8'h00);
    endtask

    // the ninth word read must give back what the first read captured
    task automatic t_profile;
        logic [15:0] r;
        for (int i = 0; i < 9; i++) begin
            cpu(16'(16'h3300 + i), 8'h00, 1'b1, 1'b1);
            acc(8'h00, 8'h00, 8'h08, r);
        end
        check(r, 16'h3300);
        cpu(16'h3400, 8'h00, 1'b1, 1'b1);
        acc(8'h00, 8'h00, 8'h10, r);
        acc(8'h00, 8'h00, 8'h08, r);
        check(r, 16'h3400);
    endtask

    initial begin
        #1000000;
        fails++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        cpuAddr = 16'h0000;
        cpuData = 8'h00;
        cpuValid = 1'b0;
        cpuRead = 1'b0;
        cpuFetch = 1'b0;
        secure = 1'b0;
        swAddr = 3'h0;
        swWdata = 8'h00;
        swWr = 1'b0;
        swRd = 1'b0;
        fails = 0;
        comparisons = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_resetVals();
        t_forceReset();
        t_endTrace();
        t_eventOnly();
        t_direction();
        t_secure();
        t_profile();
        conclude();
    end
endmodule
